// >>> verilog/adc_consts.svh
// Constants of the converter output interface
`ifndef ADC_OUTPUT_CONSTS_SVH
`define ADC_OUTPUT_CONSTS_SVH

`define WORD_WIDTH      12
`define LEVEL_WIDTH     14
`define STAGE_COUNT     5
`define PIPE_LATENCY    5
`define SYNC_WIDTH      6

`define LEVEL_MAX       14'sh07FF
`define LEVEL_MIN       -14'sh0800
`define CODE_TOP        12'hFFF
`define CODE_BOTTOM     12'h000
`define CODE_MSB_FLIP   12'h800

`define MODE_TWOS_BIT   1

`define ADDR_WIDTH      4
`define DATA_WIDTH      32
`define REG_STATUS      4'h0
`define REG_MASK        4'h4
`define REG_INFO        4'h8
`define REG_SAMPLE      4'hC

`define EV_WIDTH        3
`define EV_RANGE        0
`define EV_WORD         1
`define EV_POWER        2
`define STATUS_RESET    3'h0
`define MASK_RESET      3'h0

`define INFO_STATE_LO   0
`define INFO_TWOS       2
`define INFO_STAB       3
`define INFO_DRIVE      4
`define SAMPLE_FLAG     12

`endif

// >>> verilog/adc_types_pkg.sv
// Types of the converter output interface
`default_nettype none

package adc_types_pkg;

  typedef enum logic [1:0] {
    PWR_NORMAL = 2'b00,
    PWR_NAP    = 2'b01,
    PWR_SLEEP  = 2'b10
  } power_state_t;

endpackage : adc_types_pkg

`default_nettype wire

// >>> verilog/level_sync.sv
// Two-flop synchroniser for pin levels
`timescale 1ns/1ns
`default_nettype none

module level_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] pin_in,
  output var  logic [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] first_stage;
  logic [WIDTH-1:0] next_first;
  logic [WIDTH-1:0] next_level;

  generate
    if (WIDTH < 1) begin : g_bad
      $error("level_sync needs WIDTH of at least one");
    end
  endgenerate

  always_comb begin
    next_first = clk_en ? pin_in : first_stage;
    next_level = clk_en ? first_stage : level_out;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      first_stage <= '0;
      level_out   <= '0;
    end else begin
      first_stage <= next_first;
      level_out   <= next_level;
    end
  end

endmodule : level_sync

`default_nettype wire

// >>> verilog/residue_stage.sv
// One pipelined conversion stage: resolves a field, passes the residue on
`timescale 1ns/1ns
`default_nettype none

module residue_stage #(
  parameter int WIDTH = 12,
  parameter int HI    = 11,
  parameter int LO    = 9
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             clk_en,
  input  wire logic             load,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] residue_in,
  input  wire logic [WIDTH-1:0] word_in,
  input  wire logic             flag_in,
  output var  logic [WIDTH-1:0] residue_out,
  output var  logic [WIDTH-1:0] word_out,
  output var  logic             flag_out
);

  localparam logic [WIDTH-1:0] ALL_ONES = {WIDTH{1'b1}};
  localparam logic [WIDTH-1:0] FIELD    = (ALL_ONES >> (WIDTH - 1 - HI)) & (ALL_ONES << LO);

  logic [WIDTH-1:0] next_residue;
  logic [WIDTH-1:0] next_word;
  logic             next_flag;

  generate
    if (HI < LO || HI >= WIDTH || LO < 0) begin : g_bad
      $error("residue_stage field out of range");
    end
  endgenerate

  always_comb begin
    next_residue = residue_out;
    next_word    = word_out;
    next_flag    = flag_out;
    if (flush) begin
      next_residue = '0;
      next_word    = '0;
      next_flag    = 1'b0;
    end else if (load) begin
      // Partial results merge as they advance, so all fields stay aligned
      next_word    = word_in | (residue_in & FIELD);  // RULE_12
      next_residue = residue_in & ~FIELD;
      next_flag    = flag_in;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      residue_out <= '0;
      word_out    <= '0;
      flag_out    <= 1'b0;
    end else if (clk_en) begin
      residue_out <= next_residue;
      word_out    <= next_word;
      flag_out    <= next_flag;
    end
  end

endmodule : residue_stage

`default_nettype wire

// >>> verilog/adc_output_core.sv
// Digital output side of a pipelined sampling converter
//
// Contract
// (RULE_01) Power up, drive low: convert, outputs driven
// (RULE_02) Power down: nap or sleep, outputs released
// (RULE_03) Receiver latches word on strobe falling edge
// (RULE_04) Twelve-bit word, bit eleven most significant
// (RULE_05) Flag high when input out of range
// (RULE_06) Format low codes select offset binary
// (RULE_07) Format high codes select two's complement
// (RULE_08) Result appears five encode cycles after sampling
// (RULE_09) Track while encode low, hold on rise
// (RULE_10) Positive input rising, complement input falling
// (RULE_11) Odd and even stages alternate per phase
// (RULE_12) Align stage results, combine before output
// (RULE_13) Midscale top bit only; two's inverts it
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "adc_consts.svh"

module adc_output_core #(
  parameter int WIDTH   = `WORD_WIDTH,
  parameter int STAGES  = `STAGE_COUNT,
  parameter int LATENCY = `PIPE_LATENCY
) (
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  input  wire logic                     clk_en,
  input  wire logic                     encode_pos,
  input  wire logic                     encode_neg,
  input  wire logic                     power_down_select,
  input  wire logic                     drive_disable,
  input  wire logic [1:0]               format_select,
  input  wire logic signed [`LEVEL_WIDTH-1:0] analog_level,
  input  wire logic [`ADDR_WIDTH-1:0]   reg_addr,
  input  wire logic [`DATA_WIDTH-1:0]   reg_wdata,
  input  wire logic                     reg_write,
  input  wire logic                     reg_read,
  output var  logic [`DATA_WIDTH-1:0]   reg_rdata,
  output var  logic [WIDTH-1:0]         sample_bits,
  output var  logic                     range_exceeded_flag,
  output var  logic                     data_valid_strobe,
  output var  logic                     output_enable,
  output var  logic                     stabiliser_on,
  output var  logic                     irq
);

  localparam int ALIGN = LATENCY - 3;

  generate
    if (WIDTH != `WORD_WIDTH || STAGES < 2 || STAGES > WIDTH || LATENCY < 4) begin : g_bad
      $error("adc_output_core parameters not supported");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [`SYNC_WIDTH-1:0] pins_sync;
  logic                   pos_s;
  logic                   neg_s;
  logic                   pd_s;
  logic                   dd_s;
  logic [1:0]             fmt_s;

  level_sync #(
    .WIDTH (`SYNC_WIDTH)
  ) u_sync (
    .clk       (clk),
    .reset_n   (reset_n),
    .clk_en    (clk_en),
    .pin_in    ({encode_pos, encode_neg, power_down_select, drive_disable, format_select}),
    .level_out (pins_sync)
  );

  assign {pos_s, neg_s, pd_s, dd_s, fmt_s} = pins_sync;

  ////////////////////////////////////////////////////////////////////////////
  // Encode phase and power state

  adc_types_pkg::power_state_t power_state;
  adc_types_pkg::power_state_t next_power_state;
  logic                        enc_phase;
  logic                        next_enc_phase;
  logic                        rise_evt;
  logic                        fall_evt;
  logic                        run;
  logic                        flush;

  always_comb begin
    next_enc_phase = enc_phase;
    // Equal levels on the pair carry no edge, so the phase holds
    if (pos_s && !neg_s) begin
      next_enc_phase = 1'b1;  // RULE_10
    end else if (!pos_s && neg_s) begin
      next_enc_phase = 1'b0;  // RULE_10
    end
    if (!pd_s) begin
      next_power_state = adc_types_pkg::PWR_NORMAL;  // RULE_01
    end else if (dd_s) begin
      next_power_state = adc_types_pkg::PWR_SLEEP;  // RULE_02
    end else begin
      next_power_state = adc_types_pkg::PWR_NAP;  // RULE_02
    end
    run      = (power_state == adc_types_pkg::PWR_NORMAL);
    flush    = (power_state == adc_types_pkg::PWR_SLEEP);
    rise_evt = run && !enc_phase && next_enc_phase;
    fall_evt = run && enc_phase && !next_enc_phase;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      enc_phase   <= 1'b0;
      power_state <= adc_types_pkg::PWR_NORMAL;
    end else if (clk_en) begin
      enc_phase   <= next_enc_phase;
      power_state <= next_power_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample and hold with range check

  logic [WIDTH-1:0] held_code;
  logic             held_flag;
  logic [WIDTH-1:0] next_held_code;
  logic             next_held_flag;

  always_comb begin
    next_held_code = held_code;
    next_held_flag = held_flag;
    if (flush) begin
      next_held_code = '0;
      next_held_flag = 1'b0;
    end else if (rise_evt) begin
      // Level is taken only at the rising phase, tracked before it
      if (analog_level > `LEVEL_MAX) begin  // RULE_09
        next_held_code = `CODE_TOP;
        next_held_flag = 1'b1;  // RULE_05
      end else if (analog_level < `LEVEL_MIN) begin
        next_held_code = `CODE_BOTTOM;
        next_held_flag = 1'b1;  // RULE_05
      end else begin
        // Offset binary: bottom to zero, midscale to top bit only
        next_held_code = analog_level[WIDTH-1:0] ^ `CODE_MSB_FLIP;  // RULE_13
        next_held_flag = 1'b0;  // RULE_05
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      held_code <= '0;
      held_flag <= 1'b0;
    end else if (clk_en) begin
      held_code <= next_held_code;
      held_flag <= next_held_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pipelined stages

  logic [WIDTH-1:0] stage_res  [0:STAGES];
  logic [WIDTH-1:0] stage_word [0:STAGES];
  logic             stage_flag [0:STAGES];

  assign stage_res[0]  = held_code;
  assign stage_word[0] = '0;
  assign stage_flag[0] = held_flag;

  generate
    for (genvar i = 0; i < STAGES; i++) begin : g_stage
      localparam int HI = (WIDTH * (STAGES - i)) / STAGES - 1;
      localparam int LO = (WIDTH * (STAGES - 1 - i)) / STAGES;
      // First, third and fifth stages take on the falling phase
      localparam bit ON_FALL = (i % 2) == 0;

      residue_stage #(
        .WIDTH (WIDTH),
        .HI    (HI),
        .LO    (LO)
      ) u_stage (
        .clk         (clk),
        .reset_n     (reset_n),
        .clk_en      (clk_en),
        .load        (ON_FALL ? fall_evt : rise_evt),  // RULE_11
        .flush       (flush),
        .residue_in  (stage_res[i]),
        .word_in     (stage_word[i]),
        .flag_in     (stage_flag[i]),
        .residue_out (stage_res[i+1]),
        .word_out    (stage_word[i+1]),
        .flag_out    (stage_flag[i+1])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Alignment, format and output drivers

  logic [WIDTH:0]   align_q    [0:ALIGN-1];
  logic [WIDTH:0]   next_align [0:ALIGN-1];
  logic [WIDTH-1:0] next_sample;
  logic             next_flag_out;
  logic             next_strobe;
  logic             next_oe;
  logic             next_stab;
  logic             twos;

  always_comb begin
    twos          = fmt_s[`MODE_TWOS_BIT];  // RULE_06 RULE_07
    next_stab     = fmt_s[1] ^ fmt_s[0];
    next_sample   = sample_bits;
    next_flag_out = range_exceeded_flag;
    for (int k = 0; k < ALIGN; k++) begin
      next_align[k] = align_q[k];
    end
    if (flush) begin
      for (int k = 0; k < ALIGN; k++) begin
        next_align[k] = '0;
      end
    end else if (rise_evt) begin
      // Three more rising phases after the last stage give five in all
      next_align[0] = {stage_flag[STAGES], stage_word[STAGES]};  // RULE_08
      for (int k = 1; k < ALIGN; k++) begin
        next_align[k] = align_q[k-1];
      end
      next_sample   = align_q[ALIGN-1][WIDTH-1:0] ^ (twos ? `CODE_MSB_FLIP : `CODE_BOTTOM);  // RULE_04 RULE_13
      next_flag_out = align_q[ALIGN-1][WIDTH];  // RULE_05
    end
    next_oe = run && !dd_s;  // RULE_01 RULE_02
    // Word changes on the strobe's rise, so it is steady at its fall
    next_strobe = next_oe && next_enc_phase;  // RULE_03
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int k = 0; k < ALIGN; k++) begin
        align_q[k] <= '0;
      end
      sample_bits         <= '0;
      range_exceeded_flag <= 1'b0;
      data_valid_strobe   <= 1'b0;
      output_enable       <= 1'b0;
      stabiliser_on       <= 1'b0;
    end else if (clk_en) begin
      for (int k = 0; k < ALIGN; k++) begin
        align_q[k] <= next_align[k];
      end
      sample_bits         <= next_sample;
      range_exceeded_flag <= next_flag_out;
      data_valid_strobe   <= next_strobe;
      output_enable       <= next_oe;
      stabiliser_on       <= next_stab;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port and interrupt

  logic [`EV_WIDTH-1:0]   status;
  logic [`EV_WIDTH-1:0]   mask;
  logic [`EV_WIDTH-1:0]   next_status;
  logic [`EV_WIDTH-1:0]   next_mask;
  logic [`EV_WIDTH-1:0]   events;
  logic [`DATA_WIDTH-1:0] next_rdata;
  logic                   next_irq;

  always_comb begin
    events               = '0;
    events[`EV_RANGE]    = rise_evt && align_q[ALIGN-1][WIDTH];
    events[`EV_WORD]     = rise_evt;
    events[`EV_POWER]    = next_power_state != power_state;
    next_status          = status;
    next_mask            = mask;
    if (reg_write && reg_addr == `REG_STATUS) begin
      next_status = status & ~reg_wdata[`EV_WIDTH-1:0];
    end
    if (reg_write && reg_addr == `REG_MASK) begin
      next_mask = reg_wdata[`EV_WIDTH-1:0];
    end
    // A new event beats a clear in the same cycle
    next_status = next_status | events;
    next_irq    = |(next_status & next_mask);
    next_rdata  = '0;
    if (reg_read) begin
      unique case (reg_addr)
        `REG_STATUS: next_rdata[`EV_WIDTH-1:0] = status;
        `REG_MASK:   next_rdata[`EV_WIDTH-1:0] = mask;
        `REG_INFO: begin
          next_rdata[`INFO_STATE_LO+1:`INFO_STATE_LO] = power_state;
          next_rdata[`INFO_TWOS]  = twos;
          next_rdata[`INFO_STAB]  = stabiliser_on;
          next_rdata[`INFO_DRIVE] = output_enable;
        end
        `REG_SAMPLE: begin
          next_rdata[WIDTH-1:0]    = sample_bits;
          next_rdata[`SAMPLE_FLAG] = range_exceeded_flag;
        end
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status    <= `STATUS_RESET;
      mask      <= `MASK_RESET;
      reg_rdata <= '0;
      irq       <= 1'b0;
    end else if (clk_en) begin
      status    <= next_status;
      mask      <= next_mask;
      reg_rdata <= next_rdata;
      irq       <= next_irq;
    end
  end

endmodule : adc_output_core

`default_nettype wire

// >>> verification/capture_model.sv
// Downstream capture logic fed by the converter outputs
`timescale 1ns/1ns
`default_nettype none

module capture_model #(
  parameter int WIDTH = 12
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             data_valid_strobe,
  input  wire logic             output_enable,
  input  wire logic [WIDTH-1:0] sample_bits,
  input  wire logic             range_exceeded_flag,
  output var  logic [WIDTH-1:0] cap_word,
  output var  logic             cap_flag
);
  logic strobe_d;

  // Edge found by sampling; a released bus is never latched
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strobe_d <= 1'b0;
      cap_word <= '0;
      cap_flag <= 1'b0;
    end else begin
      strobe_d <= data_valid_strobe;
      if (strobe_d && !data_valid_strobe && output_enable) begin
        cap_word <= sample_bits;
        cap_flag <= range_exceeded_flag;
      end
    end
  end
endmodule : capture_model

`default_nettype wire

// >>> verification/adc_output_core_assertions.sv
// Port checks on the converter output interface
`timescale 1ns/1ns
`default_nettype none
`include "adc_consts.svh"

module adc_output_core_assertions (
  input wire logic                   clk,
  input wire logic                   reset_n,
  input wire logic                   clk_en,
  input wire logic                   encode_pos,
  input wire logic                   encode_neg,
  input wire logic                   power_down_select,
  input wire logic                   drive_disable,
  input wire logic                   reg_read,
  input wire logic [`DATA_WIDTH-1:0] reg_rdata,
  input wire logic                   range_exceeded_flag,
  input wire logic                   data_valid_strobe,
  input wire logic                   output_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////
  sequence s_run_pins;
    (!power_down_select && !drive_disable && clk_en)[*6];
  endsequence
  sequence s_new_word;
    $rose(data_valid_strobe) && $past(output_enable);
  endsequence

  ////////////////////////////////////////////////////////////
  a_rdata_idle_zero: assert property (clk_en && !reg_read |=> reg_rdata == '0)
    else $error("read data not zero outside read slot");
  a_strobe_needs_drive: assert property (data_valid_strobe |-> output_enable)
    else $error("strobe high while outputs released");
  a_run_drives: assert property (s_run_pins |-> output_enable)
    else $error("outputs not driven in normal mode");
  a_drive_off_release: assert property (drive_disable[*5] |-> !output_enable)
    else $error("outputs driven with drive disabled");
  a_power_down_release: assert property (power_down_select[*5] |-> !output_enable)
    else $error("outputs driven in low power state");
  a_flag_holds: assert property ($changed(range_exceeded_flag) && output_enable && $past(output_enable)
    |-> $rose(data_valid_strobe)) else $error("flag changed outside a new word");
  a_strobe_high_min: assert property ($rose(data_valid_strobe)
    |=> (data_valid_strobe || !output_enable)[*2]) else $error("strobe high phase too short");
  a_strobe_low_min: assert property ($fell(data_valid_strobe) |=> (!data_valid_strobe)[*2])
    else $error("strobe low phase too short");
  a_word_after_rise: assert property (s_new_word
    |-> $past(encode_pos, 2) && !$past(encode_neg, 2)) else $error("strobe rose without encode high");
endmodule : adc_output_core_assertions

bind adc_output_core adc_output_core_assertions chk_u (
  .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .encode_pos(encode_pos), .encode_neg(encode_neg),
  .power_down_select(power_down_select), .drive_disable(drive_disable), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .range_exceeded_flag(range_exceeded_flag),
  .data_valid_strobe(data_valid_strobe), .output_enable(output_enable)
);

`default_nettype wire

// >>> verification/pipelined_adc_output_interface_bench.sv
// Self-checking bench for the converter output interface
`timescale 1ns/1ns
`default_nettype none
`include "adc_consts.svh"

module pipelined_adc_output_interface_bench;
  logic                     clk;
  logic                     reset_n;
  logic                     clk_en;
  logic                     encode_pos;
  logic                     encode_neg;
  logic                     power_down_select;
  logic                     drive_disable;
  logic [1:0]               format_select;
  logic signed [`LEVEL_WIDTH-1:0] analog_level;
  logic [`ADDR_WIDTH-1:0]   reg_addr;
  logic [`DATA_WIDTH-1:0]   reg_wdata;
  logic                     reg_write;
  logic                     reg_read;
  logic [`DATA_WIDTH-1:0]   reg_rdata;
  logic [11:0]              sample_bits;
  logic                     range_exceeded_flag;
  logic                     data_valid_strobe;
  logic                     output_enable;
  logic                     stabiliser_on;
  logic                     irq;
  logic [11:0]              cap_word;
  logic                     cap_flag;
  logic                     enc_run = 1'b1;
  int                       num_errors = 0;
  int                       cmp_count = 0;
  int                       levels [8] = '{-2048, 2047, 0, -1, 3000, -3000, 1, 1234};

  adc_output_core dut_u (
    .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .encode_pos(encode_pos), .encode_neg(encode_neg),
    .power_down_select(power_down_select), .drive_disable(drive_disable), .format_select(format_select),
    .analog_level(analog_level), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .sample_bits(sample_bits),
    .range_exceeded_flag(range_exceeded_flag), .data_valid_strobe(data_valid_strobe),
    .output_enable(output_enable), .stabiliser_on(stabiliser_on), .irq(irq)
  );

  capture_model cap_u (
    .clk(clk), .reset_n(reset_n), .data_valid_strobe(data_valid_strobe), .output_enable(output_enable),
    .sample_bits(sample_bits), .range_exceeded_flag(range_exceeded_flag), .cap_word(cap_word), .cap_flag(cap_flag)
  );

  always #50 clk = ~clk;

  // Encode clock of 800 ns; only stops in its low phase
  initial begin
    encode_pos = 1'b0;
    encode_neg = 1'b1;
    forever begin
      repeat (4) @(posedge clk);
      if (enc_run || encode_pos) begin
        encode_pos <= ~encode_pos;
        encode_neg <= ~encode_neg;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask : reg_rd

  function automatic logic [12:0] expect_code(input int lv, input logic twos);
    logic [11:0] w;
    w = (lv > 2047) ? 12'hFFF : (lv < -2048) ? 12'h000 : 12'(lv + 2048);
    return {lv > 2047 || lv < -2048, twos ? w ^ 12'h800 : w};
  endfunction : expect_code

  ////////////////////////////////////////////////////////////
  // First six captures hold words from before this stream
  task automatic run_stream(input logic [1:0] fmt);
    logic [12:0] e;
    format_select <= fmt;
    for (int i = 0; i < 14; i++) begin
      @(negedge encode_pos);
      @(posedge clk);
      analog_level <= 14'(levels[i % 8]);
      repeat (5) @(posedge clk);
      if (i >= 6) begin
        e = expect_code(levels[(i - 6) % 8], fmt[1]);
        check("word", 32'(e[11:0]), 32'(cap_word));
        check("flag", 32'(e[12]), 32'(cap_flag));
      end
    end
    check("stabiliser", 32'(fmt[0] ^ fmt[1]), 32'(stabiliser_on));
  endtask : run_stream

  task automatic power_modes();
    logic [31:0] d;
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      power_down_select <= m[1];
      drive_disable <= m[0];
      repeat (8) @(posedge clk);
      check("output_enable", 32'(m == 0), 32'(output_enable));
      reg_rd(`REG_INFO, d);
      check("power_state", m < 2 ? 32'(adc_types_pkg::PWR_NORMAL) : m == 2 ? 32'(adc_types_pkg::PWR_NAP) :
        32'(adc_types_pkg::PWR_SLEEP), 32'(d[1:0]));
      check("info drive", 32'(m == 0), 32'(d[4]));
      check("info format", 32'h0000_0001, 32'(d[3:2]));
    end
    @(posedge clk);
    power_down_select <= 1'b0;
    drive_disable <= 1'b0;
  endtask : power_modes

  task automatic irq_regs();
    logic [31:0] d;
    enc_run = 1'b0;
    repeat (20) @(posedge clk);
    reg_wr(`REG_MASK, 32'h0000_0000);
    reg_rd(`REG_STATUS, d);
    check("status", 32'h0000_0007, d);
    check("irq masked", 32'h0000_0000, 32'(irq));
    reg_wr(`REG_MASK, 32'hFFFF_FFFF);
    reg_rd(`REG_MASK, d);
    check("mask", 32'h0000_0007, d);
    reg_wr(`REG_MASK, 32'h0000_0001);
    repeat (2) @(posedge clk);
    check("irq set", 32'h0000_0001, 32'(irq));
    reg_wr(`REG_STATUS, 32'h0000_0001);
    reg_rd(`REG_STATUS, d);
    check("status w1c", 32'h0000_0006, d);
    check("irq cleared", 32'h0000_0000, 32'(irq));
    reg_wr(4'h6, 32'h0000_0007);
    reg_rd(4'h2, d);
    check("unmapped", 32'h0000_0000, d);
    reg_rd(`REG_SAMPLE, d);
    check("sample reg", 32'({cap_flag, cap_word}), d);
    // Frozen clock enable must swallow a write
    @(posedge clk);
    clk_en <= 1'b0;
    reg_wr(`REG_MASK, 32'h0000_0007);
    clk_en <= 1'b1;
    reg_rd(`REG_MASK, d);
    check("mask frozen", 32'h0000_0001, d);
  endtask : irq_regs

  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    clk_en = 1'b1;
    power_down_select = 1'b0;
    drive_disable = 1'b0;
    format_select = 2'b00;
    analog_level = '0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    for (int f = 0; f < 4; f++) run_stream(2'(f));
    power_modes();
    run_stream(2'b00);
    irq_regs();
    final_report();
  end

  // Whole run needs about 67 us
  initial begin
    #500_000;
    num_errors++;
    final_report();
  end
endmodule : pipelined_adc_output_interface_bench

`default_nettype wire
